/* dv/eeprom_model.sv */
// Behavioural serial memory answering read instructions on the pins
module eeprom_model
   import cfg_loader_pkg::*;
(
   input wire logic sel,
   input wire logic sclk,
   input wire logic wdata,
   input wire logic [DATA_W-1:0] sig_word,
   output logic dout,
   output logic drv
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic [10:0] cmd;
   logic [DATA_W-1:0] wd;

   // Word 0 is the signature, other words carry their own address
   assign wd = (cmd[7:0] == 8'h00) ? sig_word : {cmd[7:0], ~cmd[7:0]};

   // Command shifted in MSB first on clock rise under select
   always @(posedge sclk or negedge sel) begin
      if (!sel) begin
         cnt <= 0;
      end else begin
         if (cnt < 11) cmd <= {cmd[9:0], wdata};
         cnt <= cnt + 1;
      end
   end

   // Dummy bit then data MSB first, changed on clock fall
   always @(negedge sclk or negedge sel) begin
      if (!sel) begin
         drv <= 1'b0;
      end else if (cnt >= 11 && cnt <= 27 && cmd[9:8] == OP_READ) begin
         drv <= 1'b1;
         dout <= (cnt == 11) ? 1'b0 : wd[5'(27 - cnt)];
      end
   end
endmodule

/* dv/tb_top.sv */
// Bench for the configuration loader: straps, memory load, snooping, registers
module tb_top
   import cfg_loader_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WIN = 2000;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, load_done, sig_valid;
   pin_drive_t pout, poe;
   strap_t straps;
   logic [CFG_WORDS-1:0][DATA_W-1:0] cfg_words;
   logic h_en = 1'b1;
   logic h_sel = 1'b0;
   logic h_clk = 1'b0;
   logic h_wd = 1'b0;
   logic h_do = 1'b1;
   logic [DATA_W-1:0] sig_word = SIG_VALUE;
   logic ee_do, ee_drv;
   wire sel_w, clk_w, wd_w, do_w;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] r;

   always #12.5 hclk = ~hclk;

   // Pin levels from all drivers; pull-downs except read data, pulled up
   assign sel_w = poe.memory_select_pin ? pout.memory_select_pin : (h_en ? h_sel : 1'b0);
   assign clk_w = poe.memory_clock_pin ? pout.memory_clock_pin : (h_en ? h_clk : 1'b0);
   assign wd_w = poe.memory_write_data_pin ? pout.memory_write_data_pin : (h_en & h_wd);
   assign do_w = ee_drv ? ee_do : (h_en ? h_do : 1'b1);

   eeprom_model mem (.sel(sel_w), .sclk(clk_w), .wdata(wd_w), .sig_word(sig_word),
      .dout(ee_do), .drv(ee_drv));

   eeprom_config_loader #(.LOAD_WINDOW_CYC(WIN)) uut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .mem_pins_in({sel_w, clk_w, wd_w, do_w}), .mem_pins_out(pout),
      .mem_pins_oe(poe), .straps(straps), .cfg_words(cfg_words), .load_done(load_done),
      .sig_valid(sig_valid));

   // Cycle count at each rising edge; run limit
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc > 60000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One single word transfer; waits on hready at each phase
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // Reset with strap levels presented, then released before read start
   task automatic do_reset(input logic c, input logic d, input logic o);
      @(posedge hclk);
      hresetn <= 1'b0;
      h_en <= 1'b1;
      h_sel <= 1'b0;
      h_clk <= c;
      h_wd <= d;
      h_do <= o;
      repeat (16) @(posedge hclk);
      chk("oe_in_reset", 32'h0, {29'h0, poe});
      hresetn <= 1'b1;
      repeat (20) @(posedge hclk);
      chk("oe_before_read", 32'h0, {29'h0, poe});
      // Release to pull levels: select, data-in, data-out, clock
      h_sel <= 1'b0;
      @(posedge hclk);
      h_wd <= 1'b0;
      @(posedge hclk);
      h_do <= 1'b1;
      @(posedge hclk);
      h_clk <= 1'b0;
      h_en <= 1'b0;
      chk("straps", {28'h0, 1'b0, c, d, o}, {28'h0, straps});
      repeat (17) @(posedge hclk);
      chk("oe_load", 32'h7, {29'h0, poe});
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      while (load_done !== 1'b1 && n < 30000) begin
         @(posedge hclk);
         n++;
      end
      chk("load_done", 32'h1, {31'h0, load_done});
   endtask

   // Host write or other instruction, own select cycle, trailing clock
   task automatic host_frame(input logic [26:0] bits);
      @(posedge hclk);
      h_en <= 1'b1;
      h_sel <= 1'b1;
      h_clk <= 1'b0;
      h_do <= 1'b1;
      for (int i = 26; i >= 0; i--) begin
         h_wd <= bits[i];
         repeat (4) @(posedge hclk);
         h_clk <= 1'b1;
         repeat (4) @(posedge hclk);
         h_clk <= 1'b0;
      end
      repeat (4) @(posedge hclk);
      h_sel <= 1'b0;
      repeat (4) @(posedge hclk);
      h_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      h_clk <= 1'b0;
      repeat (4) @(posedge hclk);
      h_en <= 1'b0;
      repeat (10) @(posedge hclk);
   endtask

   task automatic chk_cfg_zero();
      for (int i = 0; i < CFG_WORDS; i++) chk("cfg_zero", 32'h0, {16'h0, cfg_words[i]});
   endtask

   // Strap disables loading: defaults kept, straps reported
   task automatic t_load_off();
      do_reset(1'b1, 1'b1, 1'b0);
      wait_done();
      chk("sig_off", 32'h0, {31'h0, sig_valid});
      chk_cfg_zero();
   endtask

   // Valid signature: all words loaded, pins released after window
   task automatic t_load_ok();
      logic [7:0] a;
      do_reset(1'b0, 1'b0, 1'b1);
      wait_done();
      chk("sig_ok", 32'h1, {31'h0, sig_valid});
      for (int i = 0; i < CFG_WORDS; i++) begin
         a = 8'(i);
         chk("cfg_load", {16'h0, (i == 0) ? SIG_VALUE : {a, ~a}}, {16'h0, cfg_words[i]});
      end
      repeat (5) @(posedge hclk);
      chk("oe_after", 32'h0, {29'h0, poe});
      ahb(1'b0, 32'(ADDR_STATUS), 32'h0, r);
      chk("status", 32'h0000_0017, r);
   endtask

   // Snooped writes applied, others and out-of-range ignored
   task automatic t_snoop();
      host_frame({3'b101, 8'h03, 16'hbeef});
      chk("snoop_wr", 32'hbeef, {16'h0, cfg_words[3]});
      host_frame({3'b110, 8'h04, 16'h1234});
      chk("snoop_rd", 32'h0404 ^ 32'h00ff, {16'h0, cfg_words[4]});
      host_frame({3'b111, 8'h05, 16'h1234});
      chk("snoop_erase", 32'h05fa, {16'h0, cfg_words[5]});
      host_frame({3'b101, 8'h20, 16'h1234});
      ahb(1'b1, 32'(ADDR_CONTROL), 32'h0, r);
      host_frame({3'b101, 8'h05, 16'h4321});
      chk("snoop_off", 32'h05fa, {16'h0, cfg_words[5]});
      ahb(1'b1, 32'(ADDR_CONTROL), 32'h1, r);
      ahb(1'b0, 32'(ADDR_STATUS), 32'h0, r);
      chk("status_cnt", 32'h0000_0117, r);
   endtask

   // Direct register programming and an unmapped place
   task automatic t_regs();
      ahb(1'b1, 32'(ADDR_CFG_BASE) + 32'h18, 32'hffff_a5a5, r);
      ahb(1'b0, 32'(ADDR_CFG_BASE) + 32'h18, 32'h0, r);
      chk("cfg_reg", 32'h0000_a5a5, r);
      ahb(1'b1, 32'h100, 32'hffff_ffff, r);
      ahb(1'b0, 32'h100, 32'h0, r);
      chk("unmapped", 32'h0, r);
      ahb(1'b0, 32'(ADDR_CONTROL), 32'h0, r);
      chk("control", 32'h1, r);
   endtask

   // Wrong signature: loading stops, defaults kept
   task automatic t_bad_sig();
      sig_word <= 16'h1111;
      do_reset(1'b0, 1'b0, 1'b1);
      wait_done();
      chk("sig_bad", 32'h0, {31'h0, sig_valid});
      chk_cfg_zero();
   endtask

   task automatic finish_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      t_load_off();
      t_load_ok();
      t_snoop();
      t_regs();
      t_bad_sig();
      finish_test();
   end
endmodule

/* rtl/cfg_loader_pkg.sv */
package cfg_loader_pkg;
   // Timing figures and derived cycle counts
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned LOAD_WINDOW_MS = 30;
   localparam int unsigned STRAP_DELAY_NS = 200;
   localparam int unsigned READ_DELAY_NS = 800;
   localparam int unsigned SCLK_HALF_NS = 500;
   localparam int unsigned WIN_W = 21;
   localparam int unsigned LOAD_WINDOW_CYC_DEF = LOAD_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [WIN_W-1:0] STRAP_CYC =
      WIN_W'((STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [WIN_W-1:0] READ_START_CYC =
      WIN_W'((READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Serial memory framing
   localparam int unsigned CFG_WORDS = 16;
   localparam int unsigned CFG_AW = 4;
   localparam int unsigned MEM_AW = 8;
   localparam int unsigned DATA_W = 16;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] CMD_BITS = 5'h0b;
   localparam logic [4:0] FRAME_LAST = 5'h1b;
   localparam logic [4:0] SNOOP_BITS = 5'h1a;
   localparam logic [4:0] SNOOP_OVER = 5'h1b;
   localparam logic [DATA_W-1:0] SIG_VALUE = 16'h5a3c;
   localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;

   // Register map
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_CFG_BASE = 12'h040;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;

   typedef enum logic [1:0] {L_WAIT, L_SHIFT, L_GAP, L_DONE} load_state_t;

   typedef struct packed {
      logic memory_select_pin;
      logic auto_crossover;
      logic dual_colour_led;
      logic load_enable;
   } strap_t;

   typedef struct packed {
      logic memory_select_pin;
      logic memory_clock_pin;
      logic memory_write_data_pin;
   } pin_drive_t;

   typedef struct packed {
      logic memory_select_pin;
      logic memory_clock_pin;
      logic memory_write_data_pin;
      logic memory_read_data_pin;
   } pin_in_t;
endpackage

/* rtl/eeprom_config_loader.sv */
// Local design decisions: the AHB-Lite register port and the placing of the registers.
module eeprom_config_loader
   import cfg_loader_pkg::*;
#(
   parameter int unsigned LOAD_WINDOW_CYC = LOAD_WINDOW_CYC_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pin_in_t mem_pins_in,
   output pin_drive_t mem_pins_out,
   output pin_drive_t mem_pins_oe,
   output strap_t straps,
   output logic [CFG_WORDS-1:0][DATA_W-1:0] cfg_words,
   output logic load_done,
   output logic sig_valid
);
   localparam logic [WIN_W-1:0] WIN_END = WIN_W'(LOAD_WINDOW_CYC);

   pin_in_t pin_meta_r;
   pin_in_t pin_sync_r;
   strap_t pin_strap;
   logic [WIN_W-1:0] since_rst_r;
   load_state_t st_r;
   logic [7:0] half_r;
   logic tick;
   logic [4:0] bit_r;
   logic [CFG_AW-1:0] word_r;
   logic [DATA_W-1:0] rx_r;
   logic sig_ok_r;
   logic window_done_r;
   logic load_we;
   logic snoop_en;
   logic snoop_pulse;
   logic [MEM_AW-1:0] snoop_addr;
   logic [DATA_W-1:0] snoop_data;
   logic snoop_we;
   logic [7:0] snoop_cnt_r;
   logic ctrl_snoop_en_r;
   logic ap_valid;
   logic dp_wr_r;
   logic [11:0] dp_addr_r;
   logic rd_pend_r;
   logic [11:0] rd_addr_r;

   // Register address is a configuration word slot
   function automatic logic is_cfg(input logic [11:0] a);
      return (a[11:6] == ADDR_CFG_BASE[11:6]) && (a[1:0] == 2'h0);
   endfunction

   // Outgoing read command bit for the given word and bit slot
   function automatic logic cmd_bit(input logic [CFG_AW-1:0] w, input logic [4:0] b);
      logic [10:0] cmd;
      logic [3:0] idx;
      cmd = {1'b1, OP_READ, 4'h0, w};
      idx = 4'ha - b[3:0];
      return (b < CMD_BITS) ? cmd[idx] : 1'b0;
   endfunction

   // Two-stage synchronisers on all memory pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
      end else begin
         pin_meta_r <= mem_pins_in;
         pin_sync_r <= pin_meta_r;
      end
   end

   assign pin_strap = {pin_sync_r.memory_select_pin, pin_sync_r.memory_clock_pin,
                       pin_sync_r.memory_write_data_pin, pin_sync_r.memory_read_data_pin};

   // Time since reset release, saturating at window end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_rst_r <= '0;
      end else if (since_rst_r != WIN_END) begin
         since_rst_r <= since_rst_r + 21'h000001;
      end
   end

   // Strap capture once, at the sampling point
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         straps <= 4'h1;
      end else if (since_rst_r == STRAP_CYC) begin
         straps <= pin_strap;
      end
   end

   // Serial clock half-period timer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_r <= 8'h00;
      end else if (st_r == L_WAIT || st_r == L_DONE || tick) begin
         half_r <= 8'h00;
      end else begin
         half_r <= half_r + 8'h01;
      end
   end

   assign tick = (half_r == SCLK_HALF_CYC - 8'h01);
   assign load_we = (st_r == L_GAP) && tick && ((word_r == '0) ? (rx_r == SIG_VALUE) : sig_ok_r);

   // Load sequencer: signature word first, then the rest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= L_WAIT;
         bit_r <= 5'h00;
         word_r <= '0;
         rx_r <= 16'h0000;
         sig_ok_r <= 1'b0;
         mem_pins_out <= 3'h0;
      end else begin
         unique case (st_r)
            L_WAIT: begin
               if (since_rst_r == READ_START_CYC) begin
                  if (straps.load_enable) begin
                     st_r <= L_SHIFT;
                     mem_pins_out <= {1'b1, 1'b0, cmd_bit('0, 5'h00)};
                  end else begin
                     st_r <= L_DONE;
                  end
               end
            end
            L_SHIFT: begin
               if (tick && !mem_pins_out.memory_clock_pin) begin
                  mem_pins_out.memory_clock_pin <= 1'b1;
                  if (bit_r > CMD_BITS) begin
                     rx_r <= {rx_r[14:0], pin_sync_r.memory_read_data_pin};
                  end
               end else if (tick) begin
                  mem_pins_out.memory_clock_pin <= 1'b0;
                  if (bit_r == FRAME_LAST) begin
                     st_r <= L_GAP;
                     mem_pins_out.memory_select_pin <= 1'b0;
                     mem_pins_out.memory_write_data_pin <= 1'b0;
                  end else begin
                     bit_r <= bit_r + 5'h01;
                     mem_pins_out.memory_write_data_pin <= cmd_bit(word_r, bit_r + 5'h01);
                  end
               end
            end
            L_GAP: begin
               if (tick) begin
                  if (word_r == '0) begin
                     sig_ok_r <= (rx_r == SIG_VALUE);
                  end
                  if ((word_r == '0 && rx_r != SIG_VALUE) || word_r == CFG_AW'(CFG_WORDS - 1)) begin
                     st_r <= L_DONE;
                  end else begin
                     st_r <= L_SHIFT;
                     bit_r <= 5'h00;
                     word_r <= word_r + 4'h1;
                     mem_pins_out <= {1'b1, 1'b0, cmd_bit(word_r + 4'h1, 5'h00)};
                  end
               end
            end
            L_DONE: begin
               mem_pins_out <= 3'h0;
            end
         endcase
      end
   end

   // Pin drive: floating in reset, driven from read start until the window has ended and the load is done
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_pins_oe <= 3'h0;
         window_done_r <= 1'b0;
      end else if (since_rst_r == READ_START_CYC) begin
         mem_pins_oe <= 3'h7;
      end else if (since_rst_r == WIN_END && st_r == L_DONE) begin
         mem_pins_oe <= 3'h0;
         window_done_r <= 1'b1;
      end
   end

   // Status flags seen by software and the core
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_done <= 1'b0;
         sig_valid <= 1'b0;
      end else begin
         load_done <= (st_r == L_DONE);
         sig_valid <= sig_ok_r;
      end
   end

   assign snoop_en = window_done_r & ctrl_snoop_en_r;

   microwire_snoop u_snoop (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(snoop_en),
      .sel(pin_sync_r.memory_select_pin),
      .sclk(pin_sync_r.memory_clock_pin),
      .sdata(pin_sync_r.memory_write_data_pin),
      .wr_pulse(snoop_pulse),
      .wr_addr(snoop_addr),
      .wr_data(snoop_data)
   );

   assign snoop_we = snoop_pulse && (snoop_addr < MEM_AW'(CFG_WORDS));

   // AHB address phase capture
   assign ap_valid = hsel & htrans[1] & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 12'h000;
         rd_pend_r <= 1'b0;
         rd_addr_r <= 12'h000;
      end else begin
         dp_wr_r <= ap_valid & hwrite;
         rd_pend_r <= ap_valid & ~hwrite;
         if (ap_valid) begin
            dp_addr_r <= haddr[11:0];
            rd_addr_r <= haddr[11:0];
         end
      end
   end

   // Configuration words: load, then snoop, then software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < CFG_WORDS; i++) begin
            cfg_words[i] <= CFG_RESET;
         end
      end else if (load_we) begin
         cfg_words[word_r] <= rx_r;
      end else if (snoop_we) begin
         cfg_words[snoop_addr[CFG_AW-1:0]] <= snoop_data;
      end else if (dp_wr_r && is_cfg(dp_addr_r)) begin
         cfg_words[dp_addr_r[5:2]] <= hwdata[15:0];
      end
   end

   // Control register and accepted snoop count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_snoop_en_r <= CONTROL_RESET[0];
         snoop_cnt_r <= 8'h00;
      end else begin
         if (dp_wr_r && dp_addr_r == ADDR_CONTROL) begin
            ctrl_snoop_en_r <= hwdata[0];
         end
         if (snoop_we) begin
            snoop_cnt_r <= snoop_cnt_r + 8'h01;
         end
      end
   end

   // Read data after one wait state; always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         hreadyout <= ~(ap_valid & ~hwrite);
         if (rd_pend_r) begin
            if (rd_addr_r == ADDR_STATUS) begin
               hrdata <= {16'h0000, snoop_cnt_r, straps, 1'b0, window_done_r, sig_ok_r,
                          (st_r == L_DONE)};
            end else if (rd_addr_r == ADDR_CONTROL) begin
               hrdata <= {31'h0000_0000, ctrl_snoop_en_r};
            end else if (is_cfg(rd_addr_r)) begin
               hrdata <= {16'h0000, cfg_words[rd_addr_r[5:2]]};
            end else begin
               hrdata <= 32'h0000_0000;
            end
         end
      end
   end

   pins_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (since_rst_r <= READ_START_CYC) |-> (mem_pins_oe == 3'h0))
      else $error("memory pins driven before read start");
   read_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (since_rst_r == READ_START_CYC) |=> (mem_pins_oe == 3'h7) ##1 (mem_pins_oe == 3'h7))
      else $error("pins not driven at read start");
   load_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == L_SHIFT || st_r == L_GAP) |-> (mem_pins_oe == 3'h7))
      else $error("pins not driven during load");
   window_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
      window_done_r |-> !mem_pins_oe.memory_select_pin && !mem_pins_oe.memory_clock_pin)
      else $error("select or clock still driven after window");
   strap_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (since_rst_r == STRAP_CYC) |=> (straps == $past(pin_strap)))
      else $error("straps not taken at sampling point");
   strap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (since_rst_r > STRAP_CYC + 21'h000001) |-> $stable(straps))
      else $error("straps changed after sampling");
   sig_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (load_we && word_r != '0) |-> sig_ok_r && (cfg_words[0] == SIG_VALUE))
      else $error("word loaded without valid signature");
   no_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!straps.load_enable && since_rst_r > STRAP_CYC) |-> !load_we && (st_r != L_SHIFT))
      else $error("memory load while disabled by strap");
   snoop_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      snoop_we |-> window_done_r && ctrl_snoop_en_r)
      else $error("snooped write applied outside enabled window");
   snoop_apply_a: assert property (@(posedge hclk) disable iff (!hresetn)
      snoop_we |=> (cfg_words[$past(snoop_addr[CFG_AW-1:0])] == $past(snoop_data)))
      else $error("snooped write not stored");
   wdata_setup_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st_r == L_SHIFT && $rose(mem_pins_out.memory_clock_pin))
         |-> $stable(mem_pins_out.memory_write_data_pin))
      else $error("data-in changed on clock rise");

   load_ok_c: cover property (@(posedge hclk) disable iff (!hresetn)
      (st_r == L_GAP) && tick && (word_r == CFG_AW'(CFG_WORDS - 1)) && sig_ok_r);
   sig_fail_c: cover property (@(posedge hclk) disable iff (!hresetn)
      (st_r == L_GAP) && tick && (word_r == '0) && (rx_r != SIG_VALUE));
   strap_off_c: cover property (@(posedge hclk) disable iff (!hresetn)
      (since_rst_r == READ_START_CYC) && !straps.load_enable);
   snoop_store_c: cover property (@(posedge hclk) disable iff (!hresetn) snoop_we);
endmodule

/* rtl/microwire_snoop.sv */
module microwire_snoop
   import cfg_loader_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic sel,
   input wire logic sclk,
   input wire logic sdata,
   output logic wr_pulse,
   output logic [MEM_AW-1:0] wr_addr,
   output logic [DATA_W-1:0] wr_data
);
   logic sel_q_r;
   logic sclk_q_r;
   logic started_r;
   logic [4:0] cnt_r;
   logic [25:0] sr_r;
   logic sclk_rise;
   logic sel_fall;

   // Edge detection on already synchronised lines
   assign sclk_rise = sclk & ~sclk_q_r;
   assign sel_fall = sel_q_r & ~sel;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q_r <= 1'b0;
         sclk_q_r <= 1'b0;
      end else begin
         sel_q_r <= sel;
         sclk_q_r <= sclk;
      end
   end

   // Frame shifter, one instruction per select cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         started_r <= 1'b0;
         cnt_r <= 5'h00;
         sr_r <= 26'h0000000;
      end else if (!sel) begin
         started_r <= 1'b0;
         cnt_r <= 5'h00;
      end else if (sclk_rise) begin
         if (!started_r) begin
            started_r <= sdata;
         end else if (cnt_r != SNOOP_OVER) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r != SNOOP_BITS) begin
               sr_r <= {sr_r[24:0], sdata};
            end
         end
      end
   end

   // Complete WRITE frames only, judged at select fall
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pulse <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 16'h0000;
      end else begin
         wr_pulse <= enable & sel_fall & started_r & (cnt_r == SNOOP_BITS)
                     & (sr_r[25:24] == OP_WRITE);
         if (sel_fall) begin
            wr_addr <= sr_r[23:16];
            wr_data <= sr_r[15:0];
         end
      end
   end

   write_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pulse |-> ($past(sr_r[25:24]) == OP_WRITE) && ($past(cnt_r) == SNOOP_BITS)
                   && $past(sel_q_r) && !$past(sel))
      else $error("snoop pulse without a complete write frame");

   snoop_write_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_pulse);
endmodule
